// file: logic/pwg_defines.svh
// register indices, field positions, reset values and codes of the pwm
// generator channel 0; included by the package and the design modules
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH

// register indices; the byte address is four times the index
`define PWG_IDX_CTRL 8'h40
`define PWG_IDX_CLK 8'h41
`define PWG_IDX_DUTY_HI 8'h42
`define PWG_IDX_DUTY_LO 8'h43
`define PWG_IDX_BOUND_HI 8'h44
`define PWG_IDX_BOUND_LO 8'h45

// bus and counter widths
`define PWG_ADDR_W 12
`define PWG_DATA_W 32
`define PWG_CNT_W 11
`define PWG_DIV_W 7

// clock control fields
`define PWG_CLK_EN_BIT 7
`define PWG_CLK_DIV_HI 6
`define PWG_CLK_DIV_LO 4
`define PWG_CLK_SRC_BIT 0

// channel control fields
`define PWG_CTRL_STAT_BIT 6
`define PWG_CTRL_INV_BIT 5
`define PWG_CTRL_COMB_BIT 4
`define PWG_CTRL_PIN_HI 3
`define PWG_CTRL_PIN_LO 1
`define PWG_CTRL_FUNC_BIT 0

// split value fields of the low registers
`define PWG_DUTY_LO_HI 7
`define PWG_DUTY_LO_LO 5
`define PWG_BOUND_LO_HI 7
`define PWG_BOUND_LO_LO 6

// pin routing
`define PWG_PIN_COUNT 5
`define PWG_PIN_OFF 3'h0
`define PWG_PIN_SHARED 3'h5

// reset values and the fixed low bit of the bound
`define PWG_RST_BYTE 8'h00
`define PWG_RST_LOW3 3'h0
`define PWG_RST_CNT 11'h000
`define PWG_RST_DATA 32'h0000_0000
`define PWG_BOUND_BIT0 1'b1

// bus responses
`define PWG_RESP_OKAY 2'h0
`define PWG_RESP_DECERR 2'h3

`endif

// file: logic/pwg_pkg.sv
// types and the address decode helper of the pwm generator channel 0
// assumes the defines header is on the include path
`include "pwg_defines.svh"

package pwg_pkg;

	// write channel sequence, gray coded along idle, address, response
	typedef enum logic [1:0] {
		PWG_WR_IDLE = 2'h0,
		PWG_WR_HAVE_ADDR = 2'h1,
		PWG_WR_RESP = 2'h3,
		PWG_WR_HAVE_DATA = 2'h2
	} pwg_wr_state_e;

	typedef logic [`PWG_ADDR_W-1:0] pwg_addr_t;
	typedef logic [`PWG_CNT_W-1:0] pwg_cnt_t;

	// true when a byte address hits the aligned word of a register index
	function automatic logic pwg_hit(input pwg_addr_t addr,
		input logic [7:0] idx);
		return addr == {2'h0, idx, 2'h0};
	endfunction

endpackage

// file: logic/pwg_prescaler.sv
// power of two prescaler for the generator clock source
// assumes src_tick is a one cycle pulse in the aclk domain
`timescale 1ns/100ps
`include "pwg_defines.svh"

module pwg_prescaler
	import pwg_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic run,
	input wire logic [2:0] div_code,
	// ticks
	input wire logic src_tick,
	output logic tick_out
);

	logic [`PWG_DIV_W-1:0] div_cnt_q;
	logic [`PWG_DIV_W-1:0] div_cnt_d;
	logic [`PWG_DIV_W-1:0] div_mask;

	// terminal count is two to the code, minus one
	assign div_mask = `PWG_DIV_W'((8'h01 << div_code) - 8'h01);
	assign tick_out = run & src_tick & (div_cnt_q >= div_mask);

	// next count of source ticks
	always_comb begin
		div_cnt_d = div_cnt_q;
		if (!run) begin
			div_cnt_d = '0;
		end else if (src_tick) begin
			if (div_cnt_q >= div_mask) begin
				div_cnt_d = '0;
			end else begin
				div_cnt_d = div_cnt_q + `PWG_DIV_W'(1);
			end
		end
	end

	// count register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_d;
		end
	end

endmodule

// file: logic/pwg_channel0.sv
// pwm generator channel 0 with its shared clock control, on axi4-lite
// assumes the oscillator and channel 1 inputs are synchronous to aclk
`timescale 1ns/100ps
`include "pwg_defines.svh"

module pwg_channel0
	import pwg_pkg::*;
#(
	parameter logic OSC_DOUBLED = 1'b0
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [`PWG_ADDR_W-1:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [`PWG_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [`PWG_ADDR_W-1:0] araddr,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [`PWG_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// clock source and neighbour channel
	input wire logic internal_fast_oscillator,
	input wire logic pwm_channel_one,
	input wire logic port_b_line_six_ch1_owned,
	// output pins
	output logic [`PWG_PIN_COUNT-1:0] pin_out,
	output logic [`PWG_PIN_COUNT-1:0] pin_oe
);

	// register state
	logic clk_en_q, clk_en_d;
	logic [2:0] clk_div_q, clk_div_d;
	logic clk_src_q, clk_src_d;
	logic ctrl_inv_q, ctrl_inv_d;
	logic ctrl_comb_q, ctrl_comb_d;
	logic [2:0] ctrl_pin_q, ctrl_pin_d;
	logic ctrl_func_q, ctrl_func_d;
	logic [2:0] duty_stage_q, duty_stage_d;
	pwg_cnt_t duty_q, duty_d;
	logic [7:0] bound_hi_q, bound_hi_d;
	logic [1:0] bound_lo_q, bound_lo_d;

	// bus state
	pwg_wr_state_e wr_state_q, wr_state_d;
	pwg_addr_t wr_addr_q, wr_addr_d;
	logic [7:0] wr_byte_q, wr_byte_d;
	logic wr_lane_q, wr_lane_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [`PWG_DATA_W-1:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// generator state
	logic osc_prev_q, osc_prev_d;
	pwg_cnt_t cnt_q, cnt_d;
	logic raw_q, raw_d;
	logic [`PWG_PIN_COUNT-1:0] pin_out_q, pin_out_d;
	logic [`PWG_PIN_COUNT-1:0] pin_oe_q, pin_oe_d;

	// combinational helpers
	logic aw_take, w_take, do_write, ar_take;
	pwg_addr_t eff_addr;
	logic [7:0] eff_byte;
	logic eff_lane;
	logic wr_mapped;
	logic osc_tick, src_tick, gen_tick;
	pwg_cnt_t bound;
	logic gen_level, route_level;

	// write handshakes follow the write sequence state, arready is the inverse of rvalid
	assign awready = (wr_state_q == PWG_WR_IDLE) ||
		(wr_state_q == PWG_WR_HAVE_DATA);
	assign wready = (wr_state_q == PWG_WR_IDLE) ||
		(wr_state_q == PWG_WR_HAVE_ADDR);
	assign bvalid = (wr_state_q == PWG_WR_RESP);
	assign bresp = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign ar_take = arvalid & arready;

	// pick the address and data of this cycle or the captured ones
	assign eff_addr = aw_take ? awaddr : wr_addr_q;
	assign eff_byte = w_take ? wdata[7:0] : wr_byte_q;
	assign eff_lane = w_take ? wstrb[0] : wr_lane_q;
	assign do_write = (wr_state_d == PWG_WR_RESP) &&
		(wr_state_q != PWG_WR_RESP);
	assign wr_mapped = pwg_hit(eff_addr, `PWG_IDX_CTRL) ||
		pwg_hit(eff_addr, `PWG_IDX_CLK) ||
		pwg_hit(eff_addr, `PWG_IDX_DUTY_HI) ||
		pwg_hit(eff_addr, `PWG_IDX_DUTY_LO) ||
		pwg_hit(eff_addr, `PWG_IDX_BOUND_HI) ||
		pwg_hit(eff_addr, `PWG_IDX_BOUND_LO);

	// write sequence: address and data in either order, then response
	always_comb begin
		wr_state_d = wr_state_q;
		wr_addr_d = wr_addr_q;
		wr_byte_d = wr_byte_q;
		wr_lane_d = wr_lane_q;
		bresp_d = bresp_q;
		if (aw_take) begin
			wr_addr_d = awaddr;
		end
		if (w_take) begin
			wr_byte_d = wdata[7:0];
			wr_lane_d = wstrb[0];
		end
		case (wr_state_q)
			PWG_WR_IDLE: begin
				if (aw_take && w_take) begin
					wr_state_d = PWG_WR_RESP;
				end else if (aw_take) begin
					wr_state_d = PWG_WR_HAVE_ADDR;
				end else if (w_take) begin
					wr_state_d = PWG_WR_HAVE_DATA;
				end
			end
			PWG_WR_HAVE_ADDR: begin
				if (w_take) begin
					wr_state_d = PWG_WR_RESP;
				end
			end
			PWG_WR_HAVE_DATA: begin
				if (aw_take) begin
					wr_state_d = PWG_WR_RESP;
				end
			end
			default: begin
				if (bready) begin
					wr_state_d = PWG_WR_IDLE;
				end
			end
		endcase
		if (do_write) begin
			bresp_d = wr_mapped ? `PWG_RESP_OKAY : `PWG_RESP_DECERR;
		end
	end

	// write sequence registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= PWG_WR_IDLE;
			wr_addr_q <= '0;
			wr_byte_q <= `PWG_RST_BYTE;
			wr_lane_q <= 1'b0;
			bresp_q <= `PWG_RESP_OKAY;
		end else begin
			wr_state_q <= wr_state_d;
			wr_addr_q <= wr_addr_d;
			wr_byte_q <= wr_byte_d;
			wr_lane_q <= wr_lane_d;
			bresp_q <= bresp_d;
		end
	end

	// register writes; only byte lane 0 carries register bits
	always_comb begin
		clk_en_d = clk_en_q;
		clk_div_d = clk_div_q;
		clk_src_d = clk_src_q;
		ctrl_inv_d = ctrl_inv_q;
		ctrl_comb_d = ctrl_comb_q;
		ctrl_pin_d = ctrl_pin_q;
		ctrl_func_d = ctrl_func_q;
		duty_stage_d = duty_stage_q;
		duty_d = duty_q;
		bound_hi_d = bound_hi_q;
		bound_lo_d = bound_lo_q;
		if (do_write && eff_lane) begin
			if (pwg_hit(eff_addr, `PWG_IDX_CTRL)) begin
				ctrl_inv_d = eff_byte[`PWG_CTRL_INV_BIT];
				ctrl_comb_d = eff_byte[`PWG_CTRL_COMB_BIT];
				ctrl_pin_d = eff_byte[`PWG_CTRL_PIN_HI:`PWG_CTRL_PIN_LO];
				ctrl_func_d = eff_byte[`PWG_CTRL_FUNC_BIT];
			end else if (pwg_hit(eff_addr, `PWG_IDX_CLK)) begin
				clk_en_d = eff_byte[`PWG_CLK_EN_BIT];
				clk_div_d = eff_byte[`PWG_CLK_DIV_HI:`PWG_CLK_DIV_LO];
				clk_src_d = eff_byte[`PWG_CLK_SRC_BIT];
			end else if (pwg_hit(eff_addr, `PWG_IDX_DUTY_HI)) begin
				// high write loads the whole duty
				duty_d = {eff_byte, duty_stage_q};
			end else if (pwg_hit(eff_addr, `PWG_IDX_DUTY_LO)) begin
				// low bits staged until the high write
				duty_stage_d = eff_byte[`PWG_DUTY_LO_HI:`PWG_DUTY_LO_LO];
			end else if (pwg_hit(eff_addr, `PWG_IDX_BOUND_HI)) begin
				bound_hi_d = eff_byte;
			end else if (pwg_hit(eff_addr, `PWG_IDX_BOUND_LO)) begin
				bound_lo_d = eff_byte[`PWG_BOUND_LO_HI:`PWG_BOUND_LO_LO];
			end
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_en_q <= 1'b0;
			clk_div_q <= `PWG_RST_LOW3;
			clk_src_q <= 1'b0;
			ctrl_inv_q <= 1'b0;
			ctrl_comb_q <= 1'b0;
			ctrl_pin_q <= `PWG_PIN_OFF;
			ctrl_func_q <= 1'b0;
			duty_stage_q <= `PWG_RST_LOW3;
			duty_q <= `PWG_RST_CNT;
			bound_hi_q <= `PWG_RST_BYTE;
			bound_lo_q <= 2'h0;
		end else begin
			clk_en_q <= clk_en_d;
			clk_div_q <= clk_div_d;
			clk_src_q <= clk_src_d;
			ctrl_inv_q <= ctrl_inv_d;
			ctrl_comb_q <= ctrl_comb_d;
			ctrl_pin_q <= ctrl_pin_d;
			ctrl_func_q <= ctrl_func_d;
			duty_stage_q <= duty_stage_d;
			duty_q <= duty_d;
			bound_hi_q <= bound_hi_d;
			bound_lo_q <= bound_lo_d;
		end
	end

	// read answer; write only registers read zero, unmapped gets decerr
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (ar_take) begin
			rvalid_d = 1'b1;
			rdata_d = `PWG_RST_DATA;
			rresp_d = `PWG_RESP_OKAY;
			if (pwg_hit(araddr, `PWG_IDX_CTRL)) begin
				rdata_d[`PWG_CTRL_STAT_BIT] = gen_level;
				rdata_d[`PWG_CTRL_PIN_HI:`PWG_CTRL_PIN_LO] = ctrl_pin_q;
				rdata_d[`PWG_CTRL_FUNC_BIT] = ctrl_func_q;
			end else if (pwg_hit(araddr, `PWG_IDX_CLK) ||
				pwg_hit(araddr, `PWG_IDX_DUTY_HI) ||
				pwg_hit(araddr, `PWG_IDX_DUTY_LO) ||
				pwg_hit(araddr, `PWG_IDX_BOUND_HI) ||
				pwg_hit(araddr, `PWG_IDX_BOUND_LO)) begin
				rdata_d = `PWG_RST_DATA;
			end else begin
				rresp_d = `PWG_RESP_DECERR;
			end
		end
	end

	// read registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= `PWG_RST_DATA;
			rresp_q <= `PWG_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// oscillator edges as ticks, both edges when doubled
	assign osc_tick = OSC_DOUBLED ?
		(internal_fast_oscillator ^ osc_prev_q) :
		(internal_fast_oscillator & !osc_prev_q);
	assign src_tick = clk_src_q ? osc_tick : 1'b1;
	assign bound = {bound_hi_q, bound_lo_q, `PWG_BOUND_BIT0};

	// prescaler of the selected source
	pwg_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(clk_en_q),
		.div_code(clk_div_q),
		.src_tick(src_tick),
		.tick_out(gen_tick)
	);

	// counter and raw comparator output
	always_comb begin
		osc_prev_d = internal_fast_oscillator;
		cnt_d = cnt_q;
		// disabled holds the counter at zero
		if (!clk_en_q) begin
			cnt_d = `PWG_RST_CNT;
		end else if (gen_tick) begin
			if (cnt_q >= bound) begin
				cnt_d = `PWG_RST_CNT;
			end else begin
				cnt_d = cnt_q + `PWG_CNT_W'(1);
			end
		end
		raw_d = clk_en_q && (cnt_q < duty_q);
	end

	// generator registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_prev_q <= 1'b0;
			cnt_q <= `PWG_RST_CNT;
			raw_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_prev_d;
			cnt_q <= cnt_d;
			raw_q <= raw_d;
		end
	end

	assign gen_level = raw_q ^ ctrl_inv_q;
	assign route_level = !ctrl_comb_q ? gen_level :
		(ctrl_func_q ? (gen_level | pwm_channel_one) :
		(gen_level ^ pwm_channel_one));

	// pin routing, one pin per code from 1 to 5
	always_comb begin
		pin_out_d = '0;
		pin_oe_d = '0;
		for (int i = 0; i < `PWG_PIN_COUNT; i++) begin
			if (ctrl_pin_q == 3'(i + 1)) begin
				pin_oe_d[i] = 1'b1;
				pin_out_d[i] = route_level;
			end
		end
		// channel 1 keeps the shared pin
		if (ctrl_pin_q == `PWG_PIN_SHARED && port_b_line_six_ch1_owned) begin
			pin_oe_d[`PWG_PIN_COUNT-1] = 1'b0;
			pin_out_d[`PWG_PIN_COUNT-1] = 1'b0;
		end
	end

	// pin registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;

endmodule

// file: sim/pwg_channel0_properties.sv
// concurrent checks on the bus and pin ports of pwg_channel0
// assumes one clock aclk and a synchronous active low aresetn
`timescale 1ns/100ps
`include "pwg_defines.svh"

module pwg_channel0_properties
	import pwg_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	// read side
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [`PWG_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic [`PWG_DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	// pins
	input wire logic port_b_line_six_ch1_owned,
	input wire logic [`PWG_PIN_COUNT-1:0] pin_oe
);
	default clocking cb_main @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// bus answers one cycle after the transfer is taken
	a_write_answer:
		assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("no write response after taken write");
	a_read_answer:
		assert property (arvalid && arready |=> rvalid)
		else $error("no read data after taken address");
	a_write_refuse:
		assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_read_refuse:
		assert property (rvalid |-> !arready)
		else $error("read accepted while data pending");
	a_unmapped_read:
		assert property (arvalid && arready
			&& (araddr > 12'h114 || araddr < 12'h100)
			|=> rresp == `PWG_RESP_DECERR && rdata == `PWG_RST_DATA)
		else $error("unmapped read not decode error");
	// write only registers read back zero
	a_wo_reads:
		assert property (arvalid && arready && araddr >= 12'h104
			&& araddr <= 12'h114 && araddr[1:0] == 2'h0
			|=> rdata == `PWG_RST_DATA && rresp == `PWG_RESP_OKAY)
		else $error("write only register read not zero");
	a_ctrl_reserved:
		assert property (arvalid && arready && araddr == 12'h100
			|=> rdata[31:7] == 25'h000_0000 && rdata[5:4] == 2'h0)
		else $error("control read shows write only bits");
	// pin routing
	a_pin_onehot:
		assert property ($onehot0(pin_oe))
		else $error("more than one pin driven");
	a_shared_yield:
		assert property (port_b_line_six_ch1_owned |=> !pin_oe[4])
		else $error("shared pin driven while owned");
endmodule

bind pwg_channel0 pwg_channel0_properties u_props (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.arvalid, .arready, .araddr, .rvalid, .rdata, .rresp,
	.port_b_line_six_ch1_owned, .pin_oe
);

// file: sim/pwg_pin_load.sv
// external loads on the five output pins of the generator
// assumes each pad has a pull-down, so an undriven pad reads low
`timescale 1ns/100ps
`include "pwg_defines.svh"

module pwg_pin_load
	import pwg_pkg::*;
(
	// from the block
	input wire logic [`PWG_PIN_COUNT-1:0] pin_out,
	input wire logic [`PWG_PIN_COUNT-1:0] pin_oe,
	// pad levels
	output logic [`PWG_PIN_COUNT-1:0] pad
);
	// released pads fall to the pull-down level
	assign pad = pin_out & pin_oe;
endmodule

// file: sim/pwg_channel0_tb.sv
// self-checking bench for pwg_channel0 over axi4-lite
// assumes bind of the checker and the pin load model in sim/
`timescale 1ns/100ps
`include "pwg_defines.svh"

module pwg_channel0_tb
	import pwg_pkg::*;
;
	localparam logic [11:0] A_CTRL = {2'h0, `PWG_IDX_CTRL, 2'h0};
	localparam logic [11:0] A_CLK = {2'h0, `PWG_IDX_CLK, 2'h0};
	localparam logic [11:0] A_DHI = {2'h0, `PWG_IDX_DUTY_HI, 2'h0};
	localparam logic [11:0] A_DLO = {2'h0, `PWG_IDX_DUTY_LO, 2'h0};
	localparam logic [11:0] A_BHI = {2'h0, `PWG_IDX_BOUND_HI, 2'h0};
	localparam logic [11:0] A_BLO = {2'h0, `PWG_IDX_BOUND_LO, 2'h0};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic arvalid, arready, rvalid, osc, ch1, owned, osc_run;
	logic [1:0] bresp, rresp, rd_r, oc;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [4:0] pin_out, pin_oe, pad;
	int n_mismatch, n_compared;

	pwg_channel0 dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
		.bvalid(bvalid), .bready(1'b1), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
		.internal_fast_oscillator(osc), .pwm_channel_one(ch1),
		.port_b_line_six_ch1_owned(owned),
		.pin_out(pin_out), .pin_oe(pin_oe));
	pwg_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

	// clock, 100 ns period
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// oscillator at a quarter of aclk while running
	always @(posedge aclk) begin
		oc <= aresetn ? oc + 2'h1 : 2'h0;
		osc <= osc_run & oc[1];
	end

	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic tmo(input logic timed_out);
		if (timed_out) begin
			n_mismatch++;
			$display("CHECK FAILED bus wait exp answer got timeout");
			conclude();
		end
	endtask

	// one write; ready sampled before the edge that takes it
	// late offers the address one cycle after the data
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic late = 1'b0);
		logic ta, tw, tb;
		int n;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= !late;
		wvalid <= 1'b1;
		tb = 1'b0;
		n = 0;
		while (!tb && n < 50) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rd_r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			else if (late && n == 0) awvalid <= 1'b1;
			if (tw) wvalid <= 1'b0;
			n++;
		end
		tmo(!tb);
		chk("bresp", {30'h0, `PWG_RESP_OKAY}, {30'h0, rd_r});
	endtask

	// one read; data and response land in rd_v and rd_r
	task automatic rd(input logic [11:0] a);
		logic ta, tr;
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		tr = 1'b0;
		n = 0;
		while (!tr && n < 50) begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			rd_v = rdata;
			rd_r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			n++;
		end
		tmo(!tr);
	endtask

	// pin enables sampled mid cycle, at the falling edge after the second rising edge from the call
	task automatic pins(input string nm, input logic [4:0] e);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(nm, {27'h0, e}, {27'h0, pin_oe});
		@(posedge aclk);
	endtask

	// count high cycles of one pad over four whole periods
	// a 4-state count, so an unknown pad level cannot pass
	task automatic meas(input int per, hi, b, input string nm);
		logic [31:0] c;
		c = 32'h0000_0000;
		repeat (per + 8) @(posedge aclk);
		repeat (4 * per) begin
			@(negedge aclk);
			c += pad[b];
		end
		@(posedge aclk);
		chk(nm, 4 * hi, c);
	endtask

	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, arvalid, ch1, owned} = 6'h00;
		{osc_run, awaddr, araddr, wdata} = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		pins("pin_oe", 5'h00);
		rd(A_CTRL);
		chk("ctrl", 32'h0, rd_v);
		rd(A_CLK);
		chk("clk", 32'h0, rd_v);
		rd(12'h200);
		chk("rresp", {30'h0, `PWG_RESP_DECERR}, {30'h0, rd_r});
		wr(A_BHI, 8'h00);
		wr(A_BLO, 8'hC0);
		wr(A_DLO, 8'h60);
		wr(A_DHI, 8'h00);
		wr(A_CTRL, 8'h02, 1'b1);
		meas(8, 0, 0, "disabled");
		for (int c = 0; c < 8; c++) begin
			wr(A_CLK, {1'b1, c[2:0], 4'h0});
			meas(8 << c, 3 << c, 0, "prescale");
		end
		wr(A_CLK, 8'h80);
		wr(A_DLO, 8'hFF);
		meas(8, 3, 0, "staged");
		wr(A_DHI, 8'h00);
		meas(8, 7, 0, "duty_lo");
		wr(A_DLO, 8'h00);
		wr(A_DHI, 8'h01);
		meas(8, 8, 0, "duty_hi");
		wr(A_DLO, 8'h60);
		wr(A_DHI, 8'h00);
		wr(A_CTRL, 8'h22);
		meas(8, 5, 0, "invert");
		ch1 <= 1'b1;
		wr(A_CTRL, 8'h12);
		meas(8, 5, 0, "xor");
		wr(A_CTRL, 8'h13);
		meas(8, 8, 0, "or_one");
		ch1 <= 1'b0;
		meas(8, 3, 0, "or_zero");
		osc_run <= 1'b1;
		wr(A_CTRL, 8'h02);
		wr(A_CLK, 8'h81);
		meas(32, 12, 0, "osc");
		wr(A_CLK, 8'h00);
		wr(A_CTRL, 8'h22);
		rd(A_CTRL);
		chk("status", 32'h0000_0042, rd_v);
		meas(8, 8, 0, "inv_off");
		wr(A_CTRL, 8'h02);
		rd(A_CTRL);
		chk("status", 32'h0000_0002, rd_v);
		for (int p = 0; p < 8; p++) begin
			wr(A_CTRL, {4'h0, p[2:0], 1'b0});
			pins("route", (p >= 1 && p <= 5) ? 5'h1 << (p - 1) : 5'h0);
		end
		owned <= 1'b1;
		wr(A_CTRL, 8'h0A);
		pins("shared", 5'h00);
		owned <= 1'b0;
		pins("shared", 5'h10);
		conclude();
	end
endmodule
